// ---- rtl/eeprom_pkg.sv ----
// Shared constants and types for the two-wire EEPROM link.
package eeprom_pkg;
  // Timing.
  localparam int CLK_PERIOD_NS      = 40;
  localparam int WRITE_BUSY_TIME_NS = 10000000;
  localparam int WB_CYCLES          = (WRITE_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS      = 10000;
  localparam int SCL_QTR_CYCLES     = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_QTR_CYCLES     = 4;

  // Geometry.
  localparam int ADDR_W     = 9;
  localparam int WORD_W     = 8;
  localparam int PAGE_W     = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES  = 512;

  // Slave address byte layout.
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int         SA_RW    = 0;
  localparam int         SA_BLK   = 1;
  localparam int         SA_SEL   = 2;
  localparam int         SA_TYPE  = 4;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Quarters of one bus bit, as the master walks them.
  localparam logic [1:0] Q_DRIVE  = 2'h0;
  localparam logic [1:0] Q_RISE   = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL   = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_WORD = 6'h04,
    ST_DATA = 6'h08, ST_READ = 6'h10, ST_BUSY = 6'h20
  } slv_st_t;
  typedef enum logic [2:0] {M_IDLE = 3'h1, M_RUN = 3'h2, M_LOAD = 3'h4} mst_st_t;
  typedef enum logic [2:0] {SYM_START = 3'h1, SYM_BIT = 3'h2, SYM_STOP = 3'h4} sym_t;
  typedef enum logic [2:0] {STG_SLAVE = 3'h1, STG_WORD = 3'h2, STG_DATA = 3'h4} stg_t;
  typedef enum logic [1:0] {OP_WRITE = 2'h0, OP_READ_CUR = 2'h1, OP_READ_RAND = 2'h2, OP_POLL = 2'h3} op_t;
endpackage

// ---- rtl/eeprom_bus_if.sv ----
// Open-drain two-wire link joining the master end and the EEPROM end.
`timescale 1ns/1ps
interface eeprom_bus_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // A line reads high unless some end enables a low drive, as a pulled-up wire would.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// ---- rtl/eeprom_slave.sv ----
// EEPROM end of the two-wire link: command engine, page buffer and array.
`timescale 1ns/1ps
// What this block does
// RULE1: Write sends eight-bit word address after slave address.
// RULE2: Ack word and data; stop starts write cycle.
// RULE3: Ignore bus completely during write busy time.
// RULE4: Page write programs up to sixteen bytes.
// RULE5: Only low four address bits count in pages.
// RULE6: Page write may start anywhere in page.
// RULE7: Ack each data byte and advance counter.
// RULE8: Extra bytes wrap and overwrite earlier page data.
// RULE9: No ack while busy, ack once done.
// RULE10: Protected upper half: nack data, no program.
// RULE11: Read-direction slave address enters transmit mode.
// RULE12: Address counter holds last address plus one.
// RULE13: Ack read address then shift out byte.
// RULE14: Random read: dummy write, restart, read address.
// RULE15: Master ack after byte requests next byte.
// RULE16: Master nack or stop ends read, release line.
// RULE17: Read counter spans whole memory and wraps.
// RULE18: Respond only to device type 1010.
// RULE19: Lowest select bit picks block; others match pins.
// RULE20: Protection covers upper half only, when pin high.
// RULE21: Buffer page bytes, commit only written locations.
// RULE22: Start outside busy restarts address reception.
module eeprom_slave #(
  parameter int BUSY_CYCLES = eeprom_pkg::WB_CYCLES
) (
  // Clock, reset and enable
  input  wire logic   clock,
  input  wire logic   nrst,
  input  wire logic   ce,
  // Strap pins
  input  wire logic   wp,
  input  wire logic   select_bit_one,
  input  wire logic   select_bit_two,
  // Two-wire link
  eeprom_bus_if.slave bus
);
  localparam int CW = $clog2(BUSY_CYCLES + 1);

  if (BUSY_CYCLES < 1) begin : g_busy_chk
    $error("BUSY_CYCLES must be at least one");
  end

  eeprom_pkg::slv_st_t             st_r;
  eeprom_pkg::slv_st_t             nxt_r;
  logic [2:0]                      scl_sy_r;
  logic [2:0]                      sda_sy_r;
  logic [2:0]                      pin_s1_r;
  logic [2:0]                      pin_s2_r;
  logic [3:0]                      cnt_r;
  logic                            ack_r;
  logic [eeprom_pkg::WORD_W-1:0]   sh_r;
  logic [eeprom_pkg::WORD_W-1:0]   tx_r;
  logic                            sda_oe_r;
  logic                            blk_r;
  logic [eeprom_pkg::ADDR_W-1:0]   addr_r;
  logic                            dirty_r;
  logic [eeprom_pkg::PAGE_BYTES-1:0] pvalid_r;
  logic [eeprom_pkg::WORD_W-1:0]   pbuf_r [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::WORD_W-1:0]   mem [eeprom_pkg::MEM_BYTES];
  logic [CW-1:0]                   busy_cnt_r;
  logic                            scl_rise;
  logic                            scl_fall;
  logic                            start_seen;
  logic                            stop_seen;
  logic                            busy_done;
  logic                            commit;
  logic                            wp_s;
  logic [1:0]                      sel_s;
  logic [eeprom_pkg::WORD_W-1:0]   rd_byte;
  logic [eeprom_pkg::PAGE_W-1:0]   ofs;

  // Only the second stage and its delayed copy feed edge detection.
  assign scl_rise   = scl_sy_r[1] & ~scl_sy_r[2];
  assign scl_fall   = ~scl_sy_r[1] & scl_sy_r[2];
  assign start_seen = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
  assign stop_seen  = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
  assign wp_s       = pin_s2_r[0];
  assign sel_s      = pin_s2_r[2:1];
  assign busy_done  = (busy_cnt_r == '0);
  assign rd_byte    = mem[addr_r];
  assign ofs        = addr_r[eeprom_pkg::PAGE_W-1:0];
  assign commit     = (st_r != eeprom_pkg::ST_BUSY) && !start_seen && stop_seen && dirty_r;

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe_r;

  // Link lines and straps come from outside this clock domain.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else if (ce) begin
      scl_sy_r <= {scl_sy_r[1:0], bus.scl};
      sda_sy_r <= {sda_sy_r[1:0], bus.sda};
      pin_s1_r <= {select_bit_two, select_bit_one, wp};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Protocol engine.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r     <= eeprom_pkg::ST_IDLE;
      nxt_r    <= eeprom_pkg::ST_IDLE;
      cnt_r    <= 4'h0;
      ack_r    <= 1'b0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      sda_oe_r <= 1'b0;
      blk_r    <= 1'b0;
      addr_r   <= 9'h000;
      dirty_r  <= 1'b0;
      pvalid_r <= 16'h0000;
    end else if (ce) begin
      if (st_r == eeprom_pkg::ST_BUSY) begin
        // Nothing on the bus is looked at here, so polls see no acknowledge.
        if (busy_done) begin
          st_r <= eeprom_pkg::ST_IDLE; // RULE3 RULE9
        end
      end else if (start_seen) begin
        st_r     <= eeprom_pkg::ST_ADDR; // RULE22
        cnt_r    <= 4'h0;
        ack_r    <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (stop_seen) begin
        st_r     <= dirty_r ? eeprom_pkg::ST_BUSY : eeprom_pkg::ST_IDLE; // RULE2 RULE16
        dirty_r  <= 1'b0;
        ack_r    <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (st_r == eeprom_pkg::ST_READ) begin
        if (scl_rise) begin
          if (!ack_r) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (sda_sy_r[1]) begin
            st_r  <= eeprom_pkg::ST_IDLE; // RULE16
            ack_r <= 1'b0;
          end
        end else if (scl_fall) begin
          if (ack_r) begin
            tx_r     <= rd_byte; // RULE15
            sda_oe_r <= ~rd_byte[eeprom_pkg::WORD_W-1];
            addr_r   <= addr_r + 9'h001; // RULE17 RULE12
            cnt_r    <= 4'h0;
            ack_r    <= 1'b0;
          end else if (cnt_r == eeprom_pkg::ACK_SLOT) begin
            sda_oe_r <= 1'b0;
            ack_r    <= 1'b1;
          end else begin
            tx_r     <= {tx_r[eeprom_pkg::WORD_W-2:0], 1'b0}; // RULE13
            sda_oe_r <= ~tx_r[eeprom_pkg::WORD_W-2];
          end
        end
      end else if (st_r != eeprom_pkg::ST_IDLE) begin
        if (scl_rise && !ack_r && cnt_r != eeprom_pkg::ACK_SLOT) begin
          sh_r  <= {sh_r[eeprom_pkg::WORD_W-2:0], sda_sy_r[1]};
          cnt_r <= cnt_r + 4'h1;
        end else if (scl_fall && ack_r) begin
          ack_r <= 1'b0;
          cnt_r <= 4'h0;
          st_r  <= nxt_r;
          if (nxt_r == eeprom_pkg::ST_READ) begin
            tx_r     <= rd_byte; // RULE11 RULE12
            sda_oe_r <= ~rd_byte[eeprom_pkg::WORD_W-1];
            addr_r   <= addr_r + 9'h001; // RULE17
          end else begin
            sda_oe_r <= 1'b0;
          end
        end else if (scl_fall && cnt_r == eeprom_pkg::ACK_SLOT) begin
          case (st_r)
            eeprom_pkg::ST_ADDR: begin
              if (sh_r[eeprom_pkg::SA_TYPE +: 4] == eeprom_pkg::DEV_TYPE &&
                  sh_r[eeprom_pkg::SA_SEL +: 2] == sel_s) begin // RULE18 RULE19
                ack_r    <= 1'b1;
                sda_oe_r <= 1'b1;
                blk_r    <= sh_r[eeprom_pkg::SA_BLK]; // RULE19
                nxt_r    <= sh_r[eeprom_pkg::SA_RW] ? eeprom_pkg::ST_READ : eeprom_pkg::ST_WORD; // RULE11 RULE14
              end else begin
                st_r <= eeprom_pkg::ST_IDLE;
              end
            end
            eeprom_pkg::ST_WORD: begin
              ack_r    <= 1'b1; // RULE2
              sda_oe_r <= 1'b1;
              addr_r   <= {blk_r, sh_r}; // RULE1 RULE19
              pvalid_r <= 16'h0000;
              dirty_r  <= 1'b0;
              nxt_r    <= eeprom_pkg::ST_DATA;
            end
            eeprom_pkg::ST_DATA: begin
              // Protected bytes are refused, so the stop finds nothing to program.
              if (wp_s && addr_r[eeprom_pkg::ADDR_W-1]) begin
                st_r <= eeprom_pkg::ST_IDLE; // RULE10 RULE20
              end else begin
                ack_r          <= 1'b1; // RULE2 RULE7
                sda_oe_r       <= 1'b1;
                pbuf_r[ofs]    <= sh_r; // RULE21 RULE8
                pvalid_r[ofs]  <= 1'b1;
                dirty_r        <= 1'b1;
                addr_r         <= {addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], ofs + 4'h1}; // RULE5 RULE6 RULE12
                nxt_r          <= eeprom_pkg::ST_DATA;
              end
            end
            default: begin
              st_r <= eeprom_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The whole page lands in one cycle, so the busy time is pure waiting.
  always_ff @(posedge clock) begin
    if (ce && commit) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (pvalid_r[i]) begin
          mem[{addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], eeprom_pkg::PAGE_W'(i)}] <= pbuf_r[i]; // RULE4 RULE21
        end
      end
    end
  end

  // Write busy timer.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_cnt_r <= '0;
    end else if (ce) begin
      if (st_r != eeprom_pkg::ST_BUSY) begin
        busy_cnt_r <= CW'(BUSY_CYCLES - 1);
      end else if (!busy_done) begin
        busy_cnt_r <= busy_cnt_r - 1'b1; // RULE3
      end
    end
  end
endmodule

// ---- rtl/eeprom_master.sv ----
// Master end of the two-wire link: runs write, read and poll commands.
`timescale 1ns/1ps
module eeprom_master #(
  parameter int QTR_CYCLES = eeprom_pkg::SCL_QTR_CYCLES
) (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  eeprom_pkg::op_t  cmd_op,
  input  wire logic [1:0]  cmd_sel,
  input  wire logic [8:0]  cmd_addr,
  input  wire logic [7:0]  cmd_len,
  output logic             done,
  output logic             nack,
  // Write data
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  // Read data
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  input  wire logic        rd_ready,
  // Two-wire link
  eeprom_bus_if.master     bus
);
  localparam int DW = $clog2(QTR_CYCLES + 1);

  if (QTR_CYCLES < eeprom_pkg::MIN_QTR_CYCLES) begin : g_qtr_chk
    $error("QTR_CYCLES too small for the link synchronisers");
  end

  eeprom_pkg::mst_st_t mst_r;
  eeprom_pkg::sym_t    sym_r;
  eeprom_pkg::stg_t    stg_r;
  eeprom_pkg::op_t     op_r;
  logic [DW-1:0]       div_r;
  logic [1:0]          q_r;
  logic [3:0]          bit_r;
  logic [7:0]          sh_r;
  logic                tx_r;
  logic                rd_dir_r;
  logic [1:0]          sel_r;
  logic [8:0]          addr_r;
  logic [7:0]          len_r;
  logic [1:0]          sda_s_r;
  logic                scl_oe_r;
  logic                sda_oe_r;
  logic                push_v;
  logic [7:0]          push_d;
  logic                sk_valid_r;
  logic [7:0]          sk_data_r;
  logic                tick;
  logic                pop;

  assign tick         = (mst_r == eeprom_pkg::M_RUN) && (div_r == '0);
  assign pop          = rd_valid & rd_ready;
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_oe_r;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_s_r <= 2'h3;
      div_r   <= '0;
    end else if (ce) begin
      sda_s_r <= {sda_s_r[0], bus.sda};
      div_r   <= (mst_r != eeprom_pkg::M_RUN || div_r == '0) ? DW'(QTR_CYCLES - 1) : div_r - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mst_r     <= eeprom_pkg::M_IDLE;
      sym_r     <= eeprom_pkg::SYM_START;
      stg_r     <= eeprom_pkg::STG_SLAVE;
      op_r      <= eeprom_pkg::OP_WRITE;
      q_r       <= eeprom_pkg::Q_DRIVE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 1'b1;
      rd_dir_r  <= 1'b0;
      sel_r     <= 2'h0;
      addr_r    <= 9'h000;
      len_r     <= 8'h01;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      cmd_ready <= 1'b1;
      wr_ready  <= 1'b0;
      done      <= 1'b0;
      nack      <= 1'b0;
      push_v    <= 1'b0;
      push_d    <= 8'h00;
    end else if (ce) begin
      done   <= 1'b0;
      push_v <= 1'b0;
      case (mst_r)
        eeprom_pkg::M_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_r      <= cmd_op;
            sel_r     <= cmd_sel;
            addr_r    <= cmd_addr;
            len_r     <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            rd_dir_r  <= (cmd_op == eeprom_pkg::OP_READ_CUR);
            stg_r     <= eeprom_pkg::STG_SLAVE;
            sym_r     <= eeprom_pkg::SYM_START;
            q_r       <= eeprom_pkg::Q_DRIVE;
            nack      <= 1'b0;
            mst_r     <= eeprom_pkg::M_RUN;
          end
        end
        eeprom_pkg::M_LOAD: begin
          if (op_r == eeprom_pkg::OP_WRITE) begin
            if (wr_valid && wr_ready) begin
              wr_ready <= 1'b0;
              sh_r     <= wr_data;
              tx_r     <= 1'b1;
              mst_r    <= eeprom_pkg::M_RUN;
            end else begin
              wr_ready <= 1'b1;
            end
          end else if (!sk_valid_r) begin
            // A full read buffer holds the clock low here, so no byte is lost.
            tx_r  <= 1'b0;
            mst_r <= eeprom_pkg::M_RUN;
          end
        end
        eeprom_pkg::M_RUN: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              eeprom_pkg::Q_DRIVE: begin
                scl_oe_r <= 1'b1;
                if (sym_r == eeprom_pkg::SYM_START) begin
                  sda_oe_r <= 1'b0;
                end else if (sym_r == eeprom_pkg::SYM_STOP) begin
                  sda_oe_r <= 1'b1;
                end else if (bit_r != eeprom_pkg::ACK_SLOT) begin
                  sda_oe_r <= tx_r & ~sh_r[7];
                end else begin
                  sda_oe_r <= ~tx_r && (len_r != 8'h01); // RULE15
                end
              end
              eeprom_pkg::Q_RISE: begin
                scl_oe_r <= 1'b0;
              end
              eeprom_pkg::Q_SAMPLE: begin
                if (sym_r == eeprom_pkg::SYM_START) begin
                  sda_oe_r <= 1'b1;
                end else if (sym_r == eeprom_pkg::SYM_STOP) begin
                  sda_oe_r <= 1'b0;
                end else if (tx_r && bit_r == eeprom_pkg::ACK_SLOT) begin
                  nack <= sda_s_r[1]; // RULE9
                end else if (!tx_r && bit_r != eeprom_pkg::ACK_SLOT) begin
                  sh_r <= {sh_r[6:0], sda_s_r[1]};
                  if (bit_r == eeprom_pkg::LAST_BIT) begin
                    push_v <= 1'b1;
                    push_d <= {sh_r[6:0], sda_s_r[1]};
                  end
                end
              end
              default: begin
                if (sym_r != eeprom_pkg::SYM_STOP) begin
                  scl_oe_r <= 1'b1;
                end
                if (sym_r == eeprom_pkg::SYM_START) begin
                  sh_r  <= {eeprom_pkg::DEV_TYPE, sel_r, addr_r[8], rd_dir_r}; // RULE18 RULE11
                  tx_r  <= 1'b1;
                  bit_r <= 4'h0;
                  sym_r <= eeprom_pkg::SYM_BIT;
                end else if (sym_r == eeprom_pkg::SYM_STOP) begin
                  done      <= 1'b1;
                  cmd_ready <= 1'b1;
                  mst_r     <= eeprom_pkg::M_IDLE;
                end else if (bit_r != eeprom_pkg::ACK_SLOT) begin
                  bit_r <= bit_r + 4'h1;
                  if (tx_r) begin
                    sh_r <= {sh_r[6:0], 1'b0};
                  end
                end else begin
                  bit_r <= 4'h0;
                  if (tx_r && nack) begin
                    sym_r <= eeprom_pkg::SYM_STOP;
                  end else begin
                    case (stg_r)
                      eeprom_pkg::STG_SLAVE: begin
                        if (rd_dir_r) begin
                          stg_r <= eeprom_pkg::STG_DATA;
                          mst_r <= eeprom_pkg::M_LOAD;
                        end else if (op_r == eeprom_pkg::OP_POLL) begin
                          sym_r <= eeprom_pkg::SYM_STOP;
                        end else begin
                          sh_r  <= addr_r[7:0]; // RULE1
                          stg_r <= eeprom_pkg::STG_WORD;
                        end
                      end
                      eeprom_pkg::STG_WORD: begin
                        if (op_r == eeprom_pkg::OP_WRITE) begin
                          stg_r <= eeprom_pkg::STG_DATA;
                          mst_r <= eeprom_pkg::M_LOAD;
                        end else begin
                          rd_dir_r <= 1'b1; // RULE14
                          stg_r    <= eeprom_pkg::STG_SLAVE;
                          sym_r    <= eeprom_pkg::SYM_START;
                        end
                      end
                      default: begin
                        if (len_r == 8'h01) begin
                          sym_r <= eeprom_pkg::SYM_STOP; // RULE7
                        end else begin
                          len_r <= len_r - 8'h01;
                          mst_r <= eeprom_pkg::M_LOAD;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: begin
          mst_r <= eeprom_pkg::M_IDLE;
        end
      endcase
    end
  end

  // Two-entry read buffer: output stage plus one spare.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_valid   <= 1'b0;
      rd_data    <= 8'h00;
      sk_valid_r <= 1'b0;
      sk_data_r  <= 8'h00;
    end else if (ce) begin
      if (!rd_valid || pop) begin
        if (sk_valid_r) begin
          rd_data    <= sk_data_r;
          rd_valid   <= 1'b1;
          sk_valid_r <= push_v;
          sk_data_r  <= push_d;
        end else begin
          rd_valid <= push_v;
          rd_data  <= push_d;
        end
      end else if (push_v) begin
        sk_valid_r <= 1'b1;
        sk_data_r  <= push_d;
      end
    end
  end
endmodule

// ---- tb/eeprom_assertions.sv ----
// Assertions on the open-drain link between the master end and the EEPROM end.
`timescale 1ns/1ps
module eeprom_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Link drives and levels
  input wire logic m_sda_oe,
  input wire logic scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_d_r;
  logic [3:0] rises_r;
  logic [5:0] high_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    scl_d_r <= scl;
  end
  // A drive held past nine rises would hide the master's acknowledge slot.
  always_ff @(posedge clock) begin
    if (!nrst || !s_sda_oe) rises_r <= 4'h0;
    else if (scl && !scl_d_r && rises_r != 4'hF) rises_r <= rises_r + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (!nrst || !scl) high_r <= 6'h00;
    else if (high_r != 6'h3F) high_r <= high_r + 6'h01;
  end
  a_reset_lines_free: assert property ($rose(nrst) |-> !(s_sda_oe | m_sda_oe | scl_oe))
    else $error("link driven after reset");
  a_slave_open_drain: assert property (s_sda_oe |-> !s_sda_o && (!$rose(s_sda_oe) || !scl))
    else $error("slave drives high or starts a drive while clock high");
  a_slave_steady_high: assert property (scl && scl_d_r |-> $stable(s_sda_oe))
    else $error("slave changed data while clock high");
  a_no_joint_drive: assert property (scl && scl_d_r |-> !(m_sda_oe && s_sda_oe))
    else $error("both ends drive data");
  a_start_by_master: assert property ($fell(sda) && scl && scl_d_r |-> m_sda_oe && !s_sda_oe)
    else $error("start not made by master");
  a_stop_by_master: assert property ($rose(sda) && scl && scl_d_r |-> $past(m_sda_oe) && !$past(s_sda_oe))
    else $error("slave held data into stop");
  a_drive_bounded: assert property (s_sda_oe |-> rises_r <= 4'h9)
    else $error("slave drive too long");
  a_idle_release: assert property (high_r > 6'h28 |-> !s_sda_oe)
    else $error("slave drives idle bus");
  cover property (scl && s_sda_oe);
  cover property ($fell(sda) && scl && scl_d_r);
  cover property ($rose(sda) && scl && scl_d_r);
endmodule

// ---- tb/serial_eeprom_rw_protocol_tb.sv ----
// Self-checking bench joining the master end and the EEPROM end over one link.
`timescale 1ns/1ps
module serial_eeprom_rw_protocol_tb;
  localparam logic [1:0] SEL = 2'h2;
  logic            clock, nrst, wp, cmd_valid, cmd_ready, done, nack, wr_valid, wr_ready, rd_valid, rd_ready;
  logic [8:0]      cmd_addr, cnt, a;
  logic [7:0]      cmd_len, wr_data, rd_data;
  logic [1:0]      cmd_sel;
  eeprom_pkg::op_t cmd_op;
  logic [7:0]      mem [512];
  bit              kn [512];
  logic [7:0]      wq [$];
  logic [7:0]      rq [$];
  int              n_errors, check_count, i, seed, nb;
  eeprom_bus_if b ();
  eeprom_master #(.QTR_CYCLES(6)) eeprom_master_i (.clock(clock), .nrst(nrst), .ce(1'b1), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .done(done),
    .nack(nack), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready), .bus(b));
  eeprom_slave #(.BUSY_CYCLES(600)) eeprom_slave_i (.clock(clock), .nrst(nrst), .ce(1'b1), .wp(wp),
    .select_bit_one(SEL[0]), .select_bit_two(SEL[1]), .bus(b));
  eeprom_assertions eeprom_assertions_i (.clock(clock), .nrst(nrst), .m_sda_oe(b.m_sda_oe), .scl_oe(b.scl_oe),
    .s_sda_o(b.s_sda_o), .s_sda_oe(b.s_sda_oe), .scl(b.scl), .sda(b.sda));
  always #20 clock = ~clock;
  function automatic logic [8:0] pg(input logic [8:0] x, input int k);
    return {x[8:4], x[3:0] + 4'(k)};
  endfunction
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Entered just after a falling edge; every input change lands on a falling edge.
  task automatic run(input eeprom_pkg::op_t op, input logic [1:0] s, input logic [8:0] x, input int n);
    int   t;
    logic ck, wk, dn;
    cmd_op = op;
    cmd_sel = s;
    cmd_addr = x;
    cmd_len = 8'(n);
    cmd_valid = 1'b1;
    ck = 1'b1;
    wk = 1'b0;
    dn = 1'b0;
    rq.delete();
    for (t = 0; t < 40000 && !(dn && !rd_valid); t++) begin
      @(negedge clock);
      if (ck) cmd_valid = 1'b0;
      ck = 1'b0;
      if (wk) wr_valid = 1'b0;
      else if (wr_ready && !wr_valid) begin
        wr_valid = 1'b1;
        wr_data = wq.pop_front();
      end
      wk = wr_valid & wr_ready;
      rd_ready = 1'($urandom);
      if (rd_valid && rd_ready) rq.push_back(rd_data);
      dn = dn | done;
    end
    chk(dn && cmd_ready === 1'b1 && wr_ready === 1'b0, "no done");
  endtask
  task automatic wr(input logic [8:0] x, input int n, input logic p);
    int k;
    int busy;
    wq.delete();
    for (k = 0; k < n; k++) begin
      wq.push_back(8'($urandom));
      if (!p) mem[pg(x, k)] = wq[k];
      if (!p) kn[pg(x, k)] = 1'b1;
    end
    run(eeprom_pkg::OP_WRITE, SEL, x, n);
    chk(nack === p, "write ack");
    if (!p) cnt = pg(x, n);
    busy = 0;
    do begin
      run(eeprom_pkg::OP_POLL, SEL, x, 1);
      busy++;
    end while (nack === 1'b1 && busy < 30);
    chk((busy > 1) == !p && busy < 30, "poll");
  endtask
  task automatic rd(input logic cur, input logic [8:0] x, input int n);
    int         k;
    logic [8:0] y;
    y = cur ? cnt : x;
    run(cur ? eeprom_pkg::OP_READ_CUR : eeprom_pkg::OP_READ_RAND, SEL, x, n);
    chk(nack === 1'b0 && rq.size() == n, "read count");
    for (k = 0; k < n; k++) begin
      if (kn[9'(y + k)]) chk(rq[k] === mem[9'(y + k)], "read data");
    end
    cnt = 9'(y + n);
  endtask
  initial begin
    repeat (95000) @(posedge clock);
    n_errors++;
    conclude;
  end
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    wp = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = eeprom_pkg::OP_WRITE;
    cmd_sel = SEL;
    cmd_addr = 9'h000;
    cmd_len = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
    cnt = 9'h000;
    seed = $urandom(32'h5A74);
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    wr(9'h1FB, 18, 1'b0);
    rd(1'b1, 9'h000, 2);
    rd(1'b0, 9'h1F0, 16);
    wr(9'h1FE, 2, 1'b0);
    wr(9'h000, 2, 1'b0);
    rd(1'b0, 9'h1FE, 4);
    wr(9'h1A0, 1, 1'b0);
    wp = 1'b1;
    wr(9'h1A0, 1, 1'b1);
    wr(9'h0A0, 1, 1'b0);
    rd(1'b0, 9'h1A0, 1);
    wp = 1'b0;
    run(eeprom_pkg::OP_POLL, ~SEL, 9'h000, 1);
    chk(nack === 1'b1, "select");
    for (i = 0; i < 6; i++) begin
      a = 9'($urandom);
      nb = 1 + $urandom % 9;
      // Unwritten bytes are unknown and would put an unknown drive on the line, so reads stay on written bytes.
      a[3:0] = 4'(a[3:0] % (17 - nb));
      wr(a, nb, 1'b0);
      rd(1'b0, a, 1 + $urandom % nb);
    end
    conclude;
  end
endmodule
